/* File: aom_pkg.sv */
package aom_pkg;
   localparam int CODE_W         = 12;
   localparam int ANA_W          = 14;
   localparam int PIPE_LAT       = 5;
   localparam int CLK_PERIOD_NS  = 10;
   localparam int CLK_MSPS       = 1000 / CLK_PERIOD_NS;
   localparam int FAST_MAX_MSPS  = 125;
   localparam int SLOW_MAX_MSPS  = 105;
   localparam int MIN_MSPS       = 1;
   localparam int NAP_WAKE_CYC   = 100;
   localparam int DCS_LOCK_CYC   = 100;
   localparam int SLEEP_WAKE_US  = 2000;
   localparam int SLEEP_WAKE_CYC = SLEEP_WAKE_US * 1000 / CLK_PERIOD_NS;
   localparam int CNT_W          = 24;
   localparam logic [CODE_W-1:0] CODE_MID = 12'h800;
   localparam logic [CODE_W-1:0] CODE_MAX = 12'hFFF;
   localparam logic [CODE_W-1:0] CODE_MIN = 12'h000;

   // Four-level format pin, coded as two digital bits
   typedef enum logic [1:0] {
      AOM_FMT_GND   = 2'b00,
      AOM_FMT_THIRD = 2'b01,
      AOM_FMT_TWO3  = 2'b10,
      AOM_FMT_VDD   = 2'b11
   } aom_fmt_t;

   typedef enum logic [1:0] {
      AOM_RUN   = 2'b00,
      AOM_NAP   = 2'b01,
      AOM_SLEEP = 2'b10,
      AOM_WAKE  = 2'b11
   } aom_pwr_t;

   // Register map of the controller
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_SAMPLE   = 8'h08;
   localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
   localparam logic [7:0] REG_IRQ_MASK = 8'h10;
   localparam int CTRL_PD        = 0;
   localparam int CTRL_OD        = 1;
   localparam int CTRL_FMT_LO    = 2;
   localparam int CTRL_CAP       = 4;
   localparam int STAT_READY     = 0;
   localparam int STAT_FLOAT     = 1;
   localparam int STAT_PD        = 2;
   localparam int SAMPLE_OF      = 12;
   localparam int IRQ_READY      = 0;
   localparam int IRQ_RANGE      = 1;
   localparam logic [4:0] CTRL_RESET = 5'h04;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Stabilizer is on for the two middle levels
   function automatic logic dcs_on(input logic [1:0] fmt);
      return fmt[0] ^ fmt[1];
   endfunction

   // Upper two levels select two's complement
   function automatic logic twos_sel(input logic [1:0] fmt);
      return fmt[1];
   endfunction
endpackage

/* File: aom_if.sv */
`timescale 1ns/1ps
// Parallel converter pins between device and controller
interface aom_if;
   logic [aom_pkg::CODE_W-1:0] sample_code_bits;
   logic                       range_exceeded_flag;
   logic                       data_drive_n;
   logic                       output_disable;
   logic                       power_down_select;
   logic [1:0]                 format_level;

   modport dev (
      output sample_code_bits,
      output range_exceeded_flag,
      output data_drive_n,
      input  output_disable,
      input  power_down_select,
      input  format_level
   );

   modport host (
      input  sample_code_bits,
      input  range_exceeded_flag,
      input  data_drive_n,
      output output_disable,
      output power_down_select,
      output format_level
   );
endinterface

/* File: aom_device.sv */
`timescale 1ns/1ps
module aom_device #(
   parameter int MAX_MSPS       = aom_pkg::FAST_MAX_MSPS,
   parameter int SLEEP_WAKE_CYC = aom_pkg::SLEEP_WAKE_CYC
) (
   input  wire logic                           aclk,
   input  wire logic                           aresetn,
   input  wire logic signed [aom_pkg::ANA_W-1:0] analog_in,
   output logic                                converter_settled,
   aom_if.dev                                  pins
);
   localparam int CW = aom_pkg::CODE_W;
   localparam int LAT = aom_pkg::PIPE_LAT;

   // Grade limit and the floor of the sample rate
   initial begin
      if (MAX_MSPS != aom_pkg::FAST_MAX_MSPS && MAX_MSPS != aom_pkg::SLOW_MAX_MSPS)
         $error("unsupported speed grade");
      if (aom_pkg::CLK_MSPS > MAX_MSPS)
         $error("conversion clock above grade limit");
      if (aom_pkg::CLK_MSPS < aom_pkg::MIN_MSPS)
         $error("conversion clock below minimum rate");
      if (SLEEP_WAKE_CYC < 1 || SLEEP_WAKE_CYC >= (1 << aom_pkg::CNT_W))
         $error("sleep wake count out of range");
      if (LAT < 1)
         $error("pipeline latency must be at least one");
   end

   ////////////////////////////////////////////////////////////////////////
   // Quantiser

   // Clamp a held input to the code range and flag overrange
   function automatic logic [CW:0] quantise(input logic signed [aom_pkg::ANA_W-1:0] v,
                                            input logic twos);
      logic [CW-1:0] code;
      logic          over;
      code = '0;
      over = 1'b0;
      if (v > $signed(14'sh07FF)) begin
         code = aom_pkg::CODE_MAX;
         over = 1'b1;
      end else if (v < $signed(14'sh3800)) begin
         code = aom_pkg::CODE_MIN;
         over = 1'b1;
      end else begin
         code = v[CW-1:0] ^ aom_pkg::CODE_MID;
      end
      if (twos)
         code = code ^ aom_pkg::CODE_MID;
      return {over, code};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Mode decode and power state

   aom_pkg::aom_pwr_t              state;
   logic [aom_pkg::CNT_W-1:0]      wake_cnt;
   logic [aom_pkg::CNT_W-1:0]      lock_cnt;
   logic                           dcs_prev;
   logic                           fmt_twos;
   logic                           fmt_dcs;
   logic [CW:0]                    pipe [LAT];
   logic                           powered_down;

   // Pin decode of the four-level format input
   assign fmt_twos = aom_pkg::twos_sel(pins.format_level);
   assign fmt_dcs  = aom_pkg::dcs_on(pins.format_level);
   assign powered_down = (state == aom_pkg::AOM_NAP) || (state == aom_pkg::AOM_SLEEP);

   // Sleep drops the reference, nap keeps it, so their wake times differ
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state    <= aom_pkg::AOM_RUN;
         wake_cnt <= '0;
      end else begin
         case (state)
            aom_pkg::AOM_RUN: begin
               if (pins.power_down_select && pins.output_disable)
                  state <= aom_pkg::AOM_SLEEP;
               else if (pins.power_down_select)
                  state <= aom_pkg::AOM_NAP;
            end
            aom_pkg::AOM_NAP: begin
               if (!pins.power_down_select) begin
                  state    <= aom_pkg::AOM_WAKE;
                  wake_cnt <= aom_pkg::CNT_W'(aom_pkg::NAP_WAKE_CYC - 1);
               end else if (pins.output_disable) begin
                  state <= aom_pkg::AOM_SLEEP;
               end
            end
            aom_pkg::AOM_SLEEP: begin
               // Reference is already down; staying asleep costs nothing
               if (!pins.power_down_select) begin
                  state    <= aom_pkg::AOM_WAKE;
                  wake_cnt <= aom_pkg::CNT_W'(SLEEP_WAKE_CYC - 1);
               end
            end
            aom_pkg::AOM_WAKE: begin
               if (pins.power_down_select && pins.output_disable)
                  state <= aom_pkg::AOM_SLEEP;
               else if (pins.power_down_select)
                  state <= aom_pkg::AOM_NAP;
               else if (wake_cnt == '0)
                  state <= aom_pkg::AOM_RUN;
               else
                  wake_cnt <= wake_cnt - 1'b1;
            end
            default: state <= aom_pkg::AOM_RUN;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Duty cycle stabilizer lock

   // Sampling always uses the rising edge of aclk; the regenerated
   // falling edge and duty correction are analog and not modelled here.
   // Turning the stabilizer on, or leaving power-down with it on, starts
   // a relock interval during which samples are not trustworthy.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lock_cnt <= '0;
         dcs_prev <= 1'b0;
      end else begin
         dcs_prev <= fmt_dcs;
         if (fmt_dcs && (!dcs_prev || powered_down))
            lock_cnt <= aom_pkg::CNT_W'(aom_pkg::DCS_LOCK_CYC - 1);
         else if (!fmt_dcs)
            lock_cnt <= '0;
         else if (lock_cnt != '0)
            lock_cnt <= lock_cnt - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Conversion pipeline

   // One sample enters per clock; word and flag travel as one vector
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < LAT; i++)
            pipe[i] <= '0;
      end else begin
         pipe[0] <= quantise(analog_in, fmt_twos);
         for (int i = 1; i < LAT; i++)
            pipe[i] <= pipe[i-1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output stage

   // Word and flag leave from the same register stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pins.sample_code_bits    <= aom_pkg::CODE_MID;
         pins.range_exceeded_flag <= 1'b0;
      end else begin
         pins.sample_code_bits    <= pipe[LAT-1][CW-1:0];
         pins.range_exceeded_flag <= pipe[LAT-1][CW];
      end
   end

   // Float all outputs when disabled or in either power-down mode
   always_ff @(posedge aclk) begin
      if (!aresetn)
         pins.data_drive_n <= 1'b1;
      else
         pins.data_drive_n <= pins.output_disable || pins.power_down_select
                              || powered_down;
   end

   // Settled only when fully awake and the stabilizer is locked
   always_ff @(posedge aclk) begin
      if (!aresetn)
         converter_settled <= 1'b0;
      else
         converter_settled <= (state == aom_pkg::AOM_RUN) && !pins.power_down_select
                              && (lock_cnt == '0);
   end
endmodule

/* File: aom_host.sv */
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module aom_host #(
   parameter int SLEEP_WAKE_CYC = aom_pkg::SLEEP_WAKE_CYC
) (
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   input  wire logic [7:0]                   s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   input  wire logic [31:0]                  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   input  wire logic [7:0]                   s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   output logic [31:0]                       s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   output logic [aom_pkg::CODE_W-1:0]        cap_code,
   output logic                              cap_range,
   output logic                              cap_valid,
   output logic                              irq,
   aom_if.host                               pins
);
   localparam int CW = aom_pkg::CODE_W;

   initial begin
      if (SLEEP_WAKE_CYC < 1 || SLEEP_WAKE_CYC >= (1 << (aom_pkg::CNT_W - 1)))
         $error("sleep wake count out of range");
   end

   logic [4:0]                ctrl;
   logic [1:0]                irq_stat;
   logic [1:0]                irq_mask;
   logic [CW:0]               sample;
   logic [aom_pkg::CNT_W-1:0] hold_cnt;
   logic                      slept;
   logic                      aw_have;
   logic                      w_have;
   logic [7:0]                aw_addr;
   logic [31:0]               w_data;
   logic                      do_write;
   logic                      ready_evt;
   logic                      range_evt;
   logic                      next_dcs;

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path

   // Address and data are taken in either order, then written together
   assign do_write = aw_have && w_have && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have       <= 1'b0;
         w_have        <= 1'b0;
         aw_addr       <= '0;
         w_data        <= '0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= aom_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have       <= 1'b1;
            w_data       <= s_axi_wdata;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == aom_pkg::REG_CTRL || aw_addr == aom_pkg::REG_IRQ_STAT
                             || aw_addr == aom_pkg::REG_IRQ_MASK)
                            ? aom_pkg::RESP_OKAY : aom_pkg::RESP_SLVERR;
            aw_have      <= 1'b0;
            w_have       <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Control register; the disable bit is frozen while capturing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl     <= aom_pkg::CTRL_RESET;
         irq_mask <= '0;
      end else if (do_write && s_axi_wstrb[0]) begin
         if (aw_addr == aom_pkg::REG_CTRL) begin
            ctrl[aom_pkg::CTRL_PD]                    <= w_data[aom_pkg::CTRL_PD];
            ctrl[aom_pkg::CTRL_FMT_LO+1:aom_pkg::CTRL_FMT_LO] <=
               w_data[aom_pkg::CTRL_FMT_LO+1:aom_pkg::CTRL_FMT_LO];
            ctrl[aom_pkg::CTRL_CAP]                   <= w_data[aom_pkg::CTRL_CAP];
            if (!ctrl[aom_pkg::CTRL_CAP])
               ctrl[aom_pkg::CTRL_OD] <= w_data[aom_pkg::CTRL_OD];
         end else if (aw_addr == aom_pkg::REG_IRQ_MASK) begin
            irq_mask <= w_data[1:0];
         end
      end
   end

   // Pins come straight from the control register
   assign pins.power_down_select = ctrl[aom_pkg::CTRL_PD];
   assign pins.output_disable    = ctrl[aom_pkg::CTRL_OD];
   assign pins.format_level      = ctrl[aom_pkg::CTRL_FMT_LO+1:aom_pkg::CTRL_FMT_LO];

   ////////////////////////////////////////////////////////////////////////
   // Recovery tracking

   // Discard window covers wake time, relock and the pipeline fill
   assign next_dcs = aom_pkg::dcs_on(pins.format_level);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_cnt <= aom_pkg::CNT_W'(aom_pkg::DCS_LOCK_CYC + aom_pkg::PIPE_LAT + 2);
         slept    <= 1'b0;
      end else if (pins.power_down_select) begin
         slept    <= slept || pins.output_disable;
         hold_cnt <= aom_pkg::CNT_W'((slept || pins.output_disable ? SLEEP_WAKE_CYC
                     : aom_pkg::NAP_WAKE_CYC) + aom_pkg::DCS_LOCK_CYC
                     + aom_pkg::PIPE_LAT + 2);
      end else begin
         slept <= 1'b0;
         if (do_write && aw_addr == aom_pkg::REG_CTRL && s_axi_wstrb[0]
             && aom_pkg::dcs_on(w_data[3:2]) && !next_dcs)
            hold_cnt <= aom_pkg::CNT_W'(aom_pkg::DCS_LOCK_CYC + aom_pkg::PIPE_LAT + 2);
         else if (hold_cnt != '0)
            hold_cnt <= hold_cnt - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture and interrupts

   // One register stage catches word and flag together
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sample    <= '0;
         cap_code  <= '0;
         cap_range <= 1'b0;
         cap_valid <= 1'b0;
      end else begin
         cap_valid <= 1'b0;
         if (ctrl[aom_pkg::CTRL_CAP] && hold_cnt == '0 && !pins.data_drive_n) begin
            sample    <= {pins.range_exceeded_flag, pins.sample_code_bits};
            cap_code  <= pins.sample_code_bits;
            cap_range <= pins.range_exceeded_flag;
            cap_valid <= 1'b1;
         end
      end
   end

   assign ready_evt = (hold_cnt == aom_pkg::CNT_W'(1)) && !pins.power_down_select;
   assign range_evt = ctrl[aom_pkg::CTRL_CAP] && hold_cnt == '0 && !pins.data_drive_n
                      && pins.range_exceeded_flag;

   // Sticky bits, write one to clear; a new event beats the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat <= '0;
         irq      <= 1'b0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == aom_pkg::IRQ_READY) ? ready_evt : range_evt)
               irq_stat[i] <= 1'b1;
            else if (do_write && aw_addr == aom_pkg::REG_IRQ_STAT && s_axi_wstrb[0] && w_data[i])
               irq_stat[i] <= 1'b0;
         end
         irq <= |(irq_stat & irq_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= aom_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= aom_pkg::RESP_OKAY;
         if (s_axi_araddr == aom_pkg::REG_CTRL)
            s_axi_rdata <= {27'h0, ctrl};
         else if (s_axi_araddr == aom_pkg::REG_STATUS)
            s_axi_rdata <= {29'h0, pins.power_down_select, pins.data_drive_n,
                            hold_cnt == '0};
         else if (s_axi_araddr == aom_pkg::REG_SAMPLE)
            s_axi_rdata <= {19'h0, sample};
         else if (s_axi_araddr == aom_pkg::REG_IRQ_STAT)
            s_axi_rdata <= {30'h0, irq_stat};
         else if (s_axi_araddr == aom_pkg::REG_IRQ_MASK)
            s_axi_rdata <= {30'h0, irq_mask};
         else begin
            s_axi_rdata <= '0;
            s_axi_rresp <= aom_pkg::RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule

/* File: aom_properties.sv */
`timescale 1ns/1ps
// Watches the converter pins between the two ends
module aom_properties (
   input wire logic                              aclk,
   input wire logic                              aresetn,
   input wire logic signed [aom_pkg::ANA_W-1:0]  analog_in,
   input wire logic [aom_pkg::CODE_W-1:0]        sample_code_bits,
   input wire logic                              range_exceeded_flag,
   input wire logic                              data_drive_n,
   input wire logic                              output_disable,
   input wire logic                              power_down_select,
   input wire logic [1:0]                        format_level
);
   logic [2:0] stab;
   logic [1:0] fmt_q;

   // Word is only predictable once the pipe is full and the format settled
   always_ff @(posedge aclk) begin
      fmt_q <= format_level;
      if (!aresetn || format_level != fmt_q) stab <= 3'h0;
      else if (stab != 3'h7) stab <= stab + 3'h1;
   end

   // Overrange on either side of the code span
   function automatic logic exp_over(input logic signed [13:0] a);
      return (a > 14'sh07FF) || (a < 14'sh3800);
   endfunction

   // Flag on top, clamped code below
   function automatic logic [12:0] exp_word(input logic signed [13:0] a, input logic [1:0] f);
      logic [11:0] c;
      logic        o;
      o = exp_over(a);
      c = (a > 14'sh07FF) ? 12'hFFF : (a < 14'sh3800) ? 12'h000 : {~a[11], a[10:0]};
      return {o, f[1] ? {~c[11], c[10:0]} : c};
   endfunction

   ////////////////////////////////////////
   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_sleep;
      power_down_select && output_disable;
   endsequence
   sequence s_nap;
      power_down_select && !output_disable;
   endsequence
   sequence s_run;
      !power_down_select && !output_disable;
   endsequence

   // Leaving power-down keeps the outputs floated one cycle longer
   chk_float_follow: assert property ($past(aresetn) |->
      data_drive_n == ($past(output_disable || power_down_select)
                       || $past(power_down_select, 2))) else $error("float lag");
   chk_sleep_float: assert property (s_sleep |=> data_drive_n)
      else $error("sleep drives");
   chk_nap_float: assert property (s_nap |=> data_drive_n)
      else $error("nap drives");
   chk_run_drive: assert property (s_run [*2] |=> !data_drive_n)
      else $error("run floats");
   chk_code_pipe: assert property (stab == 3'h7 |->
      sample_code_bits == 12'(exp_word($past(analog_in, 6), fmt_q))) else $error("bad code");
   chk_flag_pipe: assert property (stab == 3'h7 |->
      range_exceeded_flag == exp_over($past(analog_in, 6))) else $error("bad flag");
   chk_clamp_end: assert property (range_exceeded_flag |->
      (&sample_code_bits[10:0]) || !(|sample_code_bits[10:0])) else $error("not clamped");
   chk_nap_exit: assert property (s_nap [*2] ##1 s_run [*2] |=> !data_drive_n)
      else $error("nap exit");
endmodule

/* File: adc_output_mode_control_bench.sv */
`timescale 1ns/1ps
module adc_output_mode_control_bench;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, bvalid, awready, wready;
   logic arvalid = 0, rready = 0, arready, rvalid, cap_valid, cap_range, irq, settled;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, rd_d;
   logic [1:0] bresp, rresp, rsp;
   logic signed [13:0] analog_in = 0;
   logic [11:0] cap_code;
   int errors = 0, checked = 0, cyc = 0;
   aom_if bus ();
   aom_device #(.SLEEP_WAKE_CYC(300)) u_aom_device (.aclk(aclk), .aresetn(aresetn),
      .analog_in(analog_in), .converter_settled(settled), .pins(bus.dev));
   aom_host #(.SLEEP_WAKE_CYC(300)) u_aom_host (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .cap_code(cap_code), .cap_range(cap_range), .cap_valid(cap_valid), .irq(irq),
      .pins(bus.host));
   aom_properties u_aom_properties (.aclk(aclk), .aresetn(aresetn), .analog_in(analog_in),
      .sample_code_bits(bus.sample_code_bits), .range_exceeded_flag(bus.range_exceeded_flag),
      .data_drive_n(bus.data_drive_n), .output_disable(bus.output_disable),
      .power_down_select(bus.power_down_select), .format_level(bus.format_level));

   // Clock and cycle count
   always #5 aclk = ~aclk;
   always @(posedge aclk) cyc <= cyc + 1;

   ////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      rsp = bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      rd_d = rdata;
      rsp = rresp;
   endtask
   task automatic tally_and_finish;
      if (errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////
   task automatic t_regs;
      rd(8'h00);
      chk("ctrl reset", 32'h4, rd_d);
      rd(8'h14);
      chk("unmapped read", aom_pkg::RESP_SLVERR, rsp);
      wr(8'h14, 32'h1F);
      chk("unmapped write", aom_pkg::RESP_SLVERR, rsp);
   endtask
   // Every format level, both ends of scale and beyond
   task automatic t_codes;
      int v[6] = '{0, 1, 2047, -2048, 3000, -3000};
      int o;
      for (int f = 0; f < 4; f++) begin
         wr(8'h00, 32'(f << 2));
         foreach (v[i]) begin
            analog_in <= 14'(v[i]);
            repeat (8) @(posedge aclk);
            o = (v[i] > 2047) ? 4095 : (v[i] < -2048) ? 0 : v[i] + 2048;
            o = o ^ ((f >> 1) * 2048);
            chk("code", 32'(o), 32'(bus.sample_code_bits));
            chk("flag", v[i] > 2047 || v[i] < -2048, bus.range_exceeded_flag);
            chk("driving", 0, bus.data_drive_n);
         end
      end
      foreach (v[i]) begin
         @(posedge aclk);
         analog_in <= 14'(v[i]);
      end
   endtask
   // Nap or sleep, then recovery with the ready event
   task automatic t_power(input logic od, input logic msk, input int wake);
      int t0;
      wr(8'h0C, 32'h3);
      wr(8'h10, 32'(msk));
      wr(8'h00, {29'h0, 1'b1, od, 1'b1});
      repeat (2) @(posedge aclk);
      chk("floated", 1, bus.data_drive_n);
      chk("powered down", 0, settled);
      chk("irq idle", 0, irq);
      wr(8'h00, 32'h4);
      t0 = cyc;
      do rd(8'h04); while (!rd_d[0] && cyc - t0 < 2000);
      chk("wake long", 1, cyc - t0 > wake);
      chk("redriven", 0, bus.data_drive_n);
      chk("settled", 1, settled);
      repeat (2) @(posedge aclk);
      chk("irq", msk, irq);
      rd(8'h0C);
      chk("ready event", 1, rd_d & 32'h1);
      wr(8'h0C, 32'h1);
      repeat (2) @(posedge aclk);
      chk("irq cleared", 0, irq);
   endtask
   // Capture on: disable write refused, word and overrange captured
   task automatic t_cap;
      int n = 0;
      wr(8'h00, 32'h10);
      analog_in <= 14'h0005;
      wr(8'h00, 32'h12);
      repeat (8) @(posedge aclk);
      chk("disable refused", 0, bus.data_drive_n);
      do @(posedge aclk); while (!cap_valid && ++n < 50);
      chk("cap word", 32'h805, {cap_range, cap_code});
      rd(8'h08);
      chk("sample reg", 32'h805, rd_d);
      analog_in <= 14'h0BB8;
      repeat (10) @(posedge aclk);
      rd(8'h0C);
      chk("range event", 32'h2, rd_d & 32'h2);
      wr(8'h00, 32'h4);
   endtask

   ////////////////////////////////////////
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_codes;
      t_power(1'b0, 1'b1, 100);
      t_power(1'b1, 1'b0, 300);
      t_cap;
      tally_and_finish;
   end
   // Hang guard
   initial begin
      repeat (30000) @(posedge aclk);
      errors++;
      tally_and_finish;
   end
endmodule
